// >>> cbsr_pkg.sv
// cbsr_pkg: constants and carrier types for the cell balance switch register.
// assumes the serial slave engine hands over decoded register accesses, one per cycle.
package cbsr_pkg;
   localparam int CBSR_NUM_CELLS = 8;
   localparam int CBSR_ADDR_W = 8;
   localparam int CBSR_DATA_W = 8;
   localparam logic [7:0] CBSR_SLEEP_REG_ADDR = 8'h00;
   localparam logic [7:0] CBSR_BALANCE_REG_ADDR = 8'h01;
   localparam logic [7:0] CBSR_BALANCE_RESET = 8'h00;
   localparam int CBSR_BIT_CELL8 = 7;
   localparam int CBSR_BIT_CELL3 = 2;
   localparam int CBSR_BIT_CELL2 = 1;
   localparam int CBSR_BIT_CELL1 = 0;

   // one register access from the serial slave engine
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cbsr_req_s;

   // read answer back to the serial slave engine
   typedef struct packed {
      logic valid;
      logic hit;
      logic [7:0] rdata;
   } cbsr_rsp_s;
endpackage

// >>> cbsr_switch_cell.sv
// cbsr_switch_cell: one stored balance switch enable bit.
// assumes sleep_request is the stored sleep bit, a level synchronous to ref_clk.
`timescale 1ns/1ns
`default_nettype none
module cbsr_switch_cell (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic wr_en,
   input wire logic wr_bit,
   input wire logic sleep_request,
   output logic sw_on
);
   import cbsr_pkg::*;

   wire logic next_sw_on;

   // sleep overrides a write in the same cycle, so a switch can never start up during sleep
   assign next_sw_on = sleep_request ? 1'b0 : (wr_en ? wr_bit : sw_on);

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         sw_on <= 1'b0;
      end else begin
         sw_on <= next_sw_on;
      end
   end
endmodule // cbsr_switch_cell
`default_nettype wire

// >>> cbsr_balance_reg.sv
// cbsr_balance_reg: cell balance switch enable register behind the serial slave register port.
// assumes the slave engine presents one decoded access per cycle and owns the sleep register.
`timescale 1ns/1ns
`default_nettype none
module cbsr_balance_reg #(
   parameter int CELLS = cbsr_pkg::CBSR_NUM_CELLS
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire cbsr_pkg::cbsr_req_s req,
   input wire logic sleep_request,
   input wire logic monitor_enable,
   output wire cbsr_pkg::cbsr_rsp_s rsp,
   output wire logic [CELLS-1:0] balance_sw_en,
   output logic adjacent_on,
   output logic monitor_conflict
);
   import cbsr_pkg::*;

   // elaboration-time refusal of cell counts the register word cannot hold
   if (CELLS < 2 || CELLS > CBSR_DATA_W) begin : g_bad_cells
      $error("cbsr_balance_reg: CELLS must lie between 2 and the register width");
   end

   function automatic logic is_balance_addr(input logic [7:0] addr);
      return addr == CBSR_BALANCE_REG_ADDR;
   endfunction

   wire logic wr_hit;
   wire logic rd_hit;
   wire logic [CELLS-1:0] sw_state;
   wire logic [CBSR_DATA_W-1:0] read_word;
   wire logic balance_en_cell8;
   wire logic balance_en_cell3;
   wire logic balance_en_cell2;
   wire logic balance_en_cell1;
   logic rsp_valid;
   logic rsp_hit;
   logic [CBSR_DATA_W-1:0] rsp_rdata;
   logic adjacent_q;
   logic conflict_q;

   assign wr_hit = req.wr & is_balance_addr(req.addr);
   assign rd_hit = req.rd & is_balance_addr(req.addr);

   // bit n holds the switch across cell n+1
   genvar gi;
   generate
      for (gi = 0; gi < CELLS; gi++) begin : g_cell
         cbsr_switch_cell u_cell (
            .ref_clk(ref_clk),
            .sys_rst(sys_rst),
            .wr_en(wr_hit),
            .wr_bit(req.wdata[gi]),
            .sleep_request(sleep_request),
            .sw_on(sw_state[gi])
         );
      end
   endgenerate

   assign balance_en_cell8 = sw_state[CBSR_BIT_CELL8];
   assign balance_en_cell3 = sw_state[CBSR_BIT_CELL3];
   assign balance_en_cell2 = sw_state[CBSR_BIT_CELL2];
   assign balance_en_cell1 = sw_state[CBSR_BIT_CELL1];

   // named cells placed back at their bit positions, the rest pass straight through
   generate
      for (gi = 0; gi < CELLS; gi++) begin : g_drive
         if (gi == CBSR_BIT_CELL8) begin : g_c8
            assign balance_sw_en[gi] = balance_en_cell8;
         end else if (gi == CBSR_BIT_CELL3) begin : g_c3
            assign balance_sw_en[gi] = balance_en_cell3;
         end else if (gi == CBSR_BIT_CELL2) begin : g_c2
            assign balance_sw_en[gi] = balance_en_cell2;
         end else if (gi == CBSR_BIT_CELL1) begin : g_c1
            assign balance_sw_en[gi] = balance_en_cell1;
         end else begin : g_cn
            assign balance_sw_en[gi] = sw_state[gi];
         end
      end
   endgenerate

   // unused upper bits read as zero when fewer cells are built
   assign read_word = CBSR_DATA_W'(sw_state);

   // neighbours on together share a tap and starve each other of balance current
   wire logic next_adjacent;
   wire logic next_conflict;
   assign next_adjacent = |(sw_state[CELLS-1:1] & sw_state[CELLS-2:0]);
   // balancing current disturbs the tap voltages that the monitor divides
   assign next_conflict = monitor_enable & (|sw_state);

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         rsp_valid <= 1'b0;
         rsp_hit <= 1'b0;
         rsp_rdata <= CBSR_BALANCE_RESET;
      end else begin
         rsp_valid <= req.rd;
         rsp_hit <= rd_hit;
         rsp_rdata <= rd_hit ? read_word : 8'h00;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         adjacent_q <= 1'b0;
         conflict_q <= 1'b0;
      end else begin
         adjacent_q <= next_adjacent;
         conflict_q <= next_conflict;
      end
   end

   assign rsp.valid = rsp_valid;
   assign rsp.hit = rsp_hit;
   assign rsp.rdata = rsp_rdata;
   assign adjacent_on = adjacent_q;
   assign monitor_conflict = conflict_q;
endmodule // cbsr_balance_reg
`default_nettype wire

// >>> cbsr_reg_sva.sv
// checker: port assertions for the balance register.
// assumes it is bound to cbsr_balance_reg.
`timescale 1ns/1ns
`default_nettype none
module cbsr_reg_sva import cbsr_pkg::*; #(parameter int CELLS = 8) (
   input wire logic ref_clk, sys_rst, sleep_request, monitor_enable, monitor_conflict,
   input var cbsr_req_s req,
   input var cbsr_rsp_s rsp,
   input wire logic [CELLS-1:0] balance_sw_en);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   sequence wr_go; req.wr && req.addr == 8'h01 && !sleep_request; endsequence
   sequence rd_go; req.rd && req.addr == 8'h01; endsequence
   wr_store_a: assert property (wr_go |=>
      balance_sw_en == $past(req.wdata[CELLS-1:0])) else $error("write lost");
   sw_hold_a: assert property (!sleep_request && !(req.wr && req.addr == 8'h01)
      |=> $stable(balance_sw_en)) else $error("switch moved");
   sleep_off_a: assert property (sleep_request |=> balance_sw_en == '0) else $error("on in sleep");
   rd_hit_a: assert property (rd_go |=> rsp.hit && rsp.rdata == 8'($past(balance_sw_en)))
      else $error("bad read");
   rd_miss_a: assert property (req.rd && req.addr != 8'h01 |=> !rsp.hit && !rsp.rdata)
      else $error("bad miss");
   rd_valid_a: assert property (1 |=> rsp.valid == $past(req.rd)) else $error("bad valid");
   mon_flag_a: assert property (1 |=> monitor_conflict == $past(monitor_enable && |balance_sw_en))
      else $error("bad conflict");
endmodule // cbsr_reg_sva
bind cbsr_balance_reg cbsr_reg_sva #(.CELLS(CELLS)) sva (.ref_clk, .sys_rst, .req, .rsp, .sleep_request,
   .monitor_enable, .monitor_conflict, .balance_sw_en);
`default_nettype wire

// >>> cbsr_host_model.sv
// host model: decoded accesses and sleep bits.
// assumes one call at a time.
`timescale 1ns/1ns
`default_nettype none
module cbsr_host_model import cbsr_pkg::*; (
   input wire logic ref_clk,
   input var cbsr_rsp_s rsp,
   output var cbsr_req_s req,
   output var logic sleep_request,
   output var logic monitor_enable
);
   initial {req, sleep_request, monitor_enable} = '0;
   // released address and data are inverted and the strobes cleared, so stale values never look live
   task automatic acc(input logic w, input logic [7:0] a, d, output logic [7:0] q);
      @(posedge ref_clk) req <= '{w, !w, a, d};
      @(posedge ref_clk) req <= '{1'b0, 1'b0, ~a, ~d};
      // the answer stands from this edge to the next, so take it mid-cycle
      @(negedge ref_clk) q = rsp.rdata;
   endtask
   task automatic ctl(input logic s, m);
      @(posedge ref_clk) {sleep_request, monitor_enable} <= {s, m};
   endtask
endmodule // cbsr_host_model
`default_nettype wire

// >>> cbsr_balance_reg_tb_top.sv
// bench: register tests via the host model.
// assumes the checker binds itself.
`timescale 1ns/1ns
`default_nettype none
module cbsr_balance_reg_tb_top;
   import cbsr_pkg::*;
   logic ref_clk = 1'b0, sys_rst = 1'b1, sleep_request, monitor_enable, adjacent_on, monitor_conflict;
   cbsr_req_s req;
   cbsr_rsp_s rsp;
   logic [7:0] balance_sw_en, q;
   int num_errors = 0, compares = 0, cycles = 0;
   always #5 ref_clk = ~ref_clk;
   cbsr_host_model host (.ref_clk, .rsp, .req, .sleep_request, .monitor_enable);
   cbsr_balance_reg uut (.ref_clk, .sys_rst, .req, .sleep_request, .monitor_enable, .rsp, .balance_sw_en,
      .adjacent_on, .monitor_conflict);
   task automatic chk(input string n, input logic [7:0] e, g);
      compares++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic stop_test;
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         num_errors++;
         stop_test();
      end
   end
   initial begin
      repeat (10) @(posedge ref_clk);
      sys_rst <= 1'b0;
      host.acc(0, 8'h01, 8'h00, q);
      chk("reset", 8'h00, q);
      for (int n = 0; n < 8; n++) begin
         host.acc(1, 8'h01, 8'h01 << n, q);
         host.acc(0, 8'h01, 8'h00, q);
         chk("read", 8'h01 << n, q);
         chk("hit", 8'h03, {6'h00, rsp.valid, rsp.hit});
         chk("switch", 8'h01 << n, balance_sw_en);
      end
      host.acc(1, 8'h00, 8'h00, q);
      host.acc(0, 8'h00, 8'h00, q);
      chk("unmapped", 8'h00, q);
      chk("miss", 8'h02, {6'h00, rsp.valid, rsp.hit});
      chk("kept", 8'h80, balance_sw_en);
      chk("alone", 8'h00, {7'h00, adjacent_on});
      host.acc(1, 8'h01, 8'hC0, q);
      @(negedge ref_clk);
      chk("adjacent", 8'h01, {7'h00, adjacent_on});
      host.ctl(0, 1);
      repeat (2) @(negedge ref_clk);
      chk("conflict", 8'h01, {7'h00, monitor_conflict});
      host.ctl(1, 0);
      host.acc(1, 8'h01, 8'hFF, q);
      chk("sleep", 8'h00, balance_sw_en);
      @(negedge ref_clk);
      chk("idle", 8'h00, {7'h00, monitor_conflict});
      stop_test();
   end
endmodule // cbsr_balance_reg_tb_top
`default_nettype wire
